// ===== hdl/ledfd_diag.v
// Purpose: diagnostic, fault-status and command logic of an led sink driver
// Assumes: all pin inputs are asynchronous to clock and are resynchronised
// Notes: pwm counting and serial clock are sampled as ordinary inputs
//
// Summary of operation
// - early and late sets, 24 open/short each
// - early set captured on 9th count edge
// - late set captured on edge 4095/1023/255
// - result bits follow raw detector levels
// - pullup enabled only while channel off
// - adjacent check writes pass or fail result
// - adjacent result bits map blue/pins/red
// - adjacent fail latches, pulls fault low
// - probe current select drives probe strength
// - probe time select sets 10 or 20 us
// - reference open/short latch, force 10 mA
// - thermal warning latches until cleared
// - shutdown turns outputs off, flag latches
// - negate command sets markers, inverts results
// - self-test writes pass or fail result
// - fault pin from ten status bits, masked leds
// - error clear loads readout, clears gone faults
// - global reset command restores all defaults
// - four turn-on groups staggered by 3 clocks (60 ns)
// - commands decoded from top bits at latch
// - grayscale depth 0x 12-bit, 10, 11
// - mask keeps led failures off fault pin
`include "ledfd_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ledfd_diag (
   input wire clock,
   input wire reset_n,
   input wire serial_clock,
   input wire serial_data_in,
   input wire latch,
   input wire pwm_count_clock,
   input wire [23:0] open_detect,
   input wire [23:0] short_detect,
   input wire [23:0] channel_on,
   input wire [23:0] adj_short_in,
   input wire selftest_fail_in,
   input wire ref_open_in,
   input wire ref_short_in,
   input wire therm_warn_in,
   input wire therm_sd_in,
   output wire serial_data_out,
   output reg fault_output_n_o,
   output reg fault_output_n_oe_n,
   output reg force_10ma,
   output reg adj_probe_en,
   output reg adjacent_probe_current_sel,
   output reg [23:0] sink_drive,
   output reg [23:0] pullup_en
);
   // =============================================
   // input synchronisers
   // detector inputs are levels, so skew between bits only moves a sample one clock
   wire [104:0] raw;
   reg [104:0] s1_q;
   reg [104:0] s2_q;
   reg [2:0] prev_q;
   assign raw = {serial_clock, serial_data_in, latch, pwm_count_clock, open_detect,
      short_detect, channel_on, adj_short_in, selftest_fail_in, ref_open_in,
      ref_short_in, therm_warn_in, therm_sd_in};
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= 105'h0;
         s2_q <= 105'h0;
         prev_q <= 3'h0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         prev_q <= {s2_q[104], s2_q[102], s2_q[101]};
      end
   end
   wire sck_s = s2_q[104];
   wire sdi_s = s2_q[103];
   wire lat_s = s2_q[102];
   wire pwm_count_clock_s = s2_q[101];
   wire [47:0] det_s = s2_q[100:53];
   wire [23:0] on_s = s2_q[52:29];
   wire [23:0] adj_s = s2_q[28:5];
   wire st_fail_s = s2_q[4];
   wire ref_open_s = s2_q[3];
   wire ref_short_s = s2_q[2];
   wire warn_s = s2_q[1];
   wire tsd_s = s2_q[0];
   wire sck_rise = sck_s & ~prev_q[2];
   wire lat_rise = lat_s & ~prev_q[1];
   wire pwm_count_clock_rise = pwm_count_clock_s & ~prev_q[0];

   // =============================================
   // state
   reg [`LFD_SR_W-1:0] shift_q;
   reg lat_at_sck_q;
   reg c_clr_q;
   reg c_grst_q;
   reg c_adj_q;
   reg c_neg_q;
   reg c_self_q;
   reg c_fc_q;
   reg [12:0] fc_q;
   reg [1:0] neg_q;
   reg [47:0] early_q;
   reg [47:0] late_q;
   reg [11:0] gcnt_q;
   reg [2:0] adjres_q;
   reg [23:0] adj_q;
   reg [2:0] st_q;
   reg [3:0] flag_q;
   reg adj_busy_q;
   reg [10:0] adj_cnt_q;

   wire [11:0] cmd = shift_q[`LFD_CMD_HI:`LFD_CMD_LO];
   wire [12:0] gnext = {1'b0, gcnt_q} + 13'h0001;
   reg [12:0] gfull;
   always @* begin
      case (fc_q[`LFD_FC_GS_HI:`LFD_FC_GS_LO])
         2'b10: gfull = `LFD_FULL_10;
         2'b11: gfull = `LFD_FULL_8;
         default: gfull = `LFD_FULL_12;
      endcase
   end
   // probe lengths are cut to the counter width on purpose
   localparam [31:0] ADJ_LEN0 = `LFD_ADJ_CYC0;
   localparam [31:0] ADJ_LEN1 = `LFD_ADJ_CYC1;
   wire [10:0] adj_len = fc_q[`LFD_FC_ADJ_TIME] ? ADJ_LEN1[10:0] : ADJ_LEN0[10:0];
   wire [47:0] inv = {48{neg_q[0]}};
   // status order: thermal error, warning, ref short, ref open, self-test, adjacent
   wire [9:0] err_status = {flag_q, st_q, adjres_q};

   // healthy channel: early all clear, late short only (after undoing negation)
   wire [47:0] e_raw = early_q ^ inv;
   wire [47:0] l_raw = late_q ^ inv;
   wire led_fail = |(e_raw[47:24] | e_raw[23:0] | l_raw[47:24] | ~l_raw[23:0]);

   // =============================================
   // serial shift register and command decode
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         shift_q <= {`LFD_SR_W{1'b0}};
         lat_at_sck_q <= 1'b0;
         {c_clr_q, c_grst_q, c_adj_q, c_neg_q, c_self_q, c_fc_q} <= 6'h0;
      end else begin
         {c_clr_q, c_grst_q, c_adj_q, c_neg_q, c_self_q, c_fc_q} <= 6'h0;
         if (c_grst_q) begin
            shift_q <= {`LFD_SR_W{1'b0}};
            lat_at_sck_q <= 1'b0;
         end else if (c_clr_q) begin
            // readout snapshot taken before the clear lands in the flags
            shift_q <= {{(`LFD_SR_W-`LFD_RO_W){1'b0}}, early_q, late_q,
               neg_q, err_status, adj_q};
         end else if (sck_rise) begin
            shift_q <= {shift_q[`LFD_SR_W-2:0], sdi_s};
            lat_at_sck_q <= lat_s;
         end
         // pulses last one clock so a held latch cannot run a command twice
         if (lat_rise && lat_at_sck_q) begin
            c_fc_q <= (cmd == `LFD_CMD_FC);
            c_clr_q <= (cmd == `LFD_CMD_CLEAR);
            c_grst_q <= (cmd == `LFD_CMD_GRESET);
            c_adj_q <= (cmd == `LFD_CMD_ADJ);
            c_neg_q <= (cmd == `LFD_CMD_NEG);
            c_self_q <= (cmd == `LFD_CMD_SELF);
         end
      end
   end
   assign serial_data_out = shift_q[`LFD_SR_W-1];

   // =============================================
   // diagnostics and status
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fc_q <= `LFD_FC_RESET;
         neg_q <= 2'h0;
         early_q <= 48'h0;
         late_q <= 48'h0;
         gcnt_q <= 12'h0;
         adjres_q <= `LFD_RES_NONE;
         adj_q <= 24'h0;
         st_q <= `LFD_RES_NONE;
         flag_q <= 4'h0;
         adj_busy_q <= 1'b0;
         adj_cnt_q <= 11'h0;
      end else if (c_grst_q) begin
         fc_q <= `LFD_FC_RESET;
         neg_q <= 2'h0;
         early_q <= 48'h0;
         late_q <= 48'h0;
         gcnt_q <= 12'h0;
         adjres_q <= `LFD_RES_NONE;
         adj_q <= 24'h0;
         st_q <= `LFD_RES_NONE;
         flag_q <= 4'h0;
         adj_busy_q <= 1'b0;
         adj_cnt_q <= 11'h0;
      end else begin
         if (c_fc_q)
            fc_q <= shift_q[`LFD_FC_HI:`LFD_FC_LO];
         if (c_neg_q)
            neg_q <= 2'h3;
         if (pwm_count_clock_rise) begin
            // a depth change mid-cycle cannot leave the count above the new end
            gcnt_q <= (gnext >= gfull) ? 12'h0 : gnext[11:0];
            if (gnext == `LFD_EARLY_EDGE)
               early_q <= det_s ^ inv;
            // late sample lands one edge before the wrap
            if (gnext == gfull - 13'h0001)
               late_q <= det_s ^ inv;
         end
         // error clear drops only what has gone; sets below override it
         if (c_clr_q) begin
            if (adj_s == 24'h0)
               adjres_q <= `LFD_RES_NONE;
            adj_q <= adj_q & adj_s;
            if (!st_fail_s)
               st_q <= `LFD_RES_NONE;
            flag_q <= flag_q & {tsd_s, warn_s, ref_short_s, ref_open_s};
         end
         // a check command while one runs is dropped, not queued
         if (c_adj_q && !adj_busy_q) begin
            adj_busy_q <= 1'b1;
            adj_cnt_q <= adj_len;
         end else if (adj_busy_q) begin
            adj_cnt_q <= adj_cnt_q - 11'h001;
            if (adj_cnt_q == 11'h001) begin
               adj_busy_q <= 1'b0;
               adjres_q <= (adj_s == 24'h0) ? `LFD_RES_PASS : `LFD_RES_FAIL;
               adj_q <= adj_s;
            end
         end
         // a new self-test result replaces any earlier one
         if (c_self_q)
            st_q <= st_fail_s ? `LFD_RES_FAIL : `LFD_RES_PASS;
         // sets come last so they win over a clear in the same clock
         if (ref_open_s)
            flag_q[0] <= 1'b1;
         if (ref_short_s)
            flag_q[1] <= 1'b1;
         if (warn_s)
            flag_q[2] <= 1'b1;
         if (tsd_s)
            flag_q[3] <= 1'b1;
      end
   end

   // =============================================
   // pins
   wire adj_fail = (adjres_q == `LFD_RES_FAIL);
   wire st_fail = (st_q == `LFD_RES_FAIL);
   wire led_term = ~fc_q[`LFD_FC_MASK] & led_fail;
   wire fault_any = adj_fail | st_fail | (|flag_q) | led_term;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fault_output_n_o <= 1'b0;
         fault_output_n_oe_n <= 1'b1;
         force_10ma <= 1'b0;
         adj_probe_en <= 1'b0;
         adjacent_probe_current_sel <= 1'b0;
      end else begin
         fault_output_n_o <= 1'b0;
         // open drain: enable (low) pulls the pin low
         fault_output_n_oe_n <= ~fault_any;
         // follows the live condition; only the flag latches
         force_10ma <= ref_open_s | ref_short_s;
         adj_probe_en <= adj_busy_q;
         adjacent_probe_current_sel <= fc_q[`LFD_FC_ADJ_CUR];
      end
   end

   // =============================================
   // group staggering, one delay line per channel
   // the step is rounded up to whole clocks, so groups trail a little more than asked
   localparam HIST_W = (`LFD_GROUPS - 1) * `LFD_STAG_CYC + 1;
   genvar i;
   generate
      for (i = 0; i < 24; i = i + 1) begin : g_ch
         reg [HIST_W-1:0] hist_q;
         // group is channel index mod 4, each a fixed step later
         wire tap = hist_q[(i % `LFD_GROUPS) * `LFD_STAG_CYC];
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               hist_q <= {HIST_W{1'b0}};
               sink_drive[i] <= 1'b0;
               pullup_en[i] <= 1'b1;
            end else if (c_grst_q) begin
               // outputs restart from off after a global reset
               hist_q <= {HIST_W{1'b0}};
               sink_drive[i] <= 1'b0;
               pullup_en[i] <= 1'b1;
            end else begin
               hist_q <= {hist_q[HIST_W-2:0], on_s[i]};
               sink_drive[i] <= tap & ~tsd_s;
               pullup_en[i] <= ~(tap & ~tsd_s);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ===== pkg/ledfd_regs.vh
// Purpose: constants for the led fault diagnostics block
// Assumes: 50 MHz system clock
// Notes: command codes marked own are free choices of this design
`ifndef LEDFD_REGS_VH
`define LEDFD_REGS_VH
// =============================================
// timing
`define LFD_CLK_NS 20
`define LFD_CLK_MHZ 50
`define LFD_ADJ_T0_US 10
`define LFD_ADJ_T1_US 20
`define LFD_ADJ_CYC0 (`LFD_ADJ_T0_US * `LFD_CLK_MHZ)
`define LFD_ADJ_CYC1 (`LFD_ADJ_T1_US * `LFD_CLK_MHZ)
`define LFD_STAG_NS 50
`define LFD_STAG_CYC ((`LFD_STAG_NS + `LFD_CLK_NS - 1) / `LFD_CLK_NS)
`define LFD_GROUPS 4
// =============================================
// grayscale edge numbers
`define LFD_EARLY_EDGE 13'h0009
`define LFD_FULL_12 13'h1000
`define LFD_FULL_10 13'h0400
`define LFD_FULL_8 13'h0100
// =============================================
// serial frame and commands
`define LFD_SR_W 288
`define LFD_CMD_HI 287
`define LFD_CMD_LO 276
`define LFD_FC_HI 204
`define LFD_FC_LO 192
`define LFD_CMD_FC 12'h000
`define LFD_CMD_CLEAR 12'hA53
`define LFD_CMD_GRESET 12'hA5C
`define LFD_CMD_ADJ 12'hA51
`define LFD_CMD_NEG 12'hA55
`define LFD_CMD_SELF 12'hA56
// =============================================
// function control field positions (within the 13-bit word)
`define LFD_FC_MASK 12
`define LFD_FC_ADJ_CUR 8
`define LFD_FC_ADJ_TIME 7
`define LFD_FC_GS_HI 6
`define LFD_FC_GS_LO 5
`define LFD_FC_RESET 13'h1000
// =============================================
// check results and readout layout
`define LFD_RES_NONE 3'h0
`define LFD_RES_PASS 3'h3
`define LFD_RES_FAIL 3'h6
`define LFD_RO_W 132
`endif

// ===== tb/ledfd_diag_monitor.sv
// Purpose: port checker for ledfd_diag
// Assumes: one clock domain, async low reset
// Notes: bounds allow for the two-stage input sync
`timescale 1ns/1ps
`default_nettype none
module ledfd_diag_mon (
   input wire clock,
   input wire reset_n,
   input wire [23:0] channel_on,
   input wire ref_open_in,
   input wire ref_short_in,
   input wire therm_warn_in,
   input wire therm_sd_in,
   input wire fault_output_n_o,
   input wire fault_output_n_oe_n,
   input wire force_10ma,
   input wire adj_probe_en,
   input wire adjacent_probe_current_sel,
   input wire [23:0] sink_drive,
   input wire [23:0] pullup_en
);
   // ====
   // probe window length, too long to unroll
   reg [10:0] win_q;
   wire [10:0] win_d = adj_probe_en ? win_q + 11'h001 : 11'h000;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         win_q <= 11'h000;
      end else begin
         win_q <= win_d;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_pull; (sink_drive & pullup_en) == 24'h000000; endproperty
   a_pull: assert property (p_pull) else $error("pullup on driven channel");
   property p_stag;
      $rose(sink_drive[0]) && !sink_drive[1] && channel_on[1]
         |-> !sink_drive[1] [*3] ##1 sink_drive[1];
   endproperty
   a_stag: assert property (p_stag) else $error("group step wrong");
   property p_sd; therm_sd_in [*6] |-> sink_drive == 24'h000000; endproperty
   a_sd: assert property (p_sd) else $error("drive during shutdown");
   property p_win; $fell(adj_probe_en) |-> win_q == 11'h1F4 || win_q == 11'h3E8; endproperty
   a_win: assert property (p_win) else $error("probe window length");
   property p_cur; adj_probe_en && $past(adj_probe_en) |-> $stable(adjacent_probe_current_sel);
   endproperty
   a_cur: assert property (p_cur) else $error("probe current moved");
   property p_frc; (ref_open_in || ref_short_in) [*5] |-> force_10ma; endproperty
   a_frc: assert property (p_frc) else $error("no forced current");
   property p_ref; force_10ma |-> ##[0:2] !fault_output_n_oe_n; endproperty
   a_ref: assert property (p_ref) else $error("reference fault not on pin");
   property p_warn; therm_warn_in [*6] |-> !fault_output_n_oe_n; endproperty
   a_warn: assert property (p_warn) else $error("warning not on pin");
   property p_od; fault_output_n_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("fault pin drives high");
endmodule
bind ledfd_diag ledfd_diag_mon u_mon (.clock(clock), .reset_n(reset_n),
   .channel_on(channel_on), .ref_open_in(ref_open_in), .ref_short_in(ref_short_in),
   .therm_warn_in(therm_warn_in), .therm_sd_in(therm_sd_in),
   .fault_output_n_o(fault_output_n_o), .fault_output_n_oe_n(fault_output_n_oe_n),
   .force_10ma(force_10ma), .adj_probe_en(adj_probe_en),
   .adjacent_probe_current_sel(adjacent_probe_current_sel),
   .sink_drive(sink_drive), .pullup_en(pullup_en));
`default_nettype wire

// ===== tb/ledfd_host_model.sv
// Purpose: host side of the serial shift link
// Assumes: driven at the falling clock edge
// Notes: rd holds the previous shift register image after each frame
`timescale 1ns/1ps
`default_nettype none
module ledfd_host_model (
   input wire logic clock,
   input wire logic serial_data_out,
   output var logic serial_clock,
   output var logic serial_data_in,
   output var logic latch,
   output var logic [287:0] rd
);
   initial begin
      serial_clock = 1'h0;
      serial_data_in = 1'h0;
      latch = 1'h0;
      rd = '0;
   end
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask
   // ====
   // one 288-bit frame, msb first; second latch rise acts
   task automatic frame(input logic [11:0] cmd, input logic [12:0] fc, input logic lat);
      logic [287:0] d;
      d = {cmd, 71'h0, fc, 192'h0};
      for (int i = 287; i >= 0; i--) begin
         rd = {rd[286:0], serial_data_out};
         serial_data_in = d[i];
         if (i == 0) latch = lat;
         step(3);
         serial_clock = 1'h1;
         step(3);
         serial_clock = 1'h0;
      end
      serial_data_in = ~d[0];
      step(3);
      latch = 1'h0;
      step(3);
      latch = lat;
      step(3);
      latch = 1'h0;
      step(8);
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench for ledfd_diag
// Assumes: host model owns the serial pins
// Notes: timing windows are left to the monitor
`include "ledfd_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic pwm_count_clock = 1'h0;
   logic selftest_fail_in = 1'h0;
   logic [3:0] cond = 4'h0;
   logic [23:0] open_detect = 24'h0, short_detect = 24'h0, channel_on = 24'h0;
   logic [23:0] adj_short_in = 24'h0;
   wire sdo, sck, sdi, lat, fo, oe_n, f10, ape, cur;
   wire [23:0] sink_drive, pullup_en;
   wire [287:0] rd;
   int mismatches = 0, num_checks = 0;
   always #10 clock = ~clock;
   ledfd_diag DUT (.clock(clock), .reset_n(reset_n), .serial_clock(sck),
      .serial_data_in(sdi), .latch(lat), .pwm_count_clock(pwm_count_clock),
      .open_detect(open_detect), .short_detect(short_detect), .channel_on(channel_on),
      .adj_short_in(adj_short_in), .selftest_fail_in(selftest_fail_in),
      .ref_open_in(cond[0]), .ref_short_in(cond[1]), .therm_warn_in(cond[2]),
      .therm_sd_in(cond[3]), .serial_data_out(sdo), .fault_output_n_o(fo),
      .fault_output_n_oe_n(oe_n), .force_10ma(f10), .adj_probe_en(ape),
      .adjacent_probe_current_sel(cur), .sink_drive(sink_drive), .pullup_en(pullup_en));
   ledfd_host_model host (.clock(clock), .serial_data_out(sdo), .serial_clock(sck),
      .serial_data_in(sdi), .latch(lat), .rd(rd));
   // ====
   // helpers
   task chk(input logic [287:0] seen, input logic [287:0] exp, input string nm);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task print_verdict;
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task rdo;
      host.frame(`LFD_CMD_CLEAR, 13'h0, 1'h1);
      host.frame(12'h000, 13'h0, 1'h0);
   endtask
   // channels with o clear read healthy at edge 9, short high at the late edge
   task pcycle(input logic [23:0] o, input int n);
      for (int e = 1; e <= n; e++) begin
         open_detect = o;
         short_detect = (e > 12) ? 24'hFFFFFF : 24'h000000;
         cyc(3);
         pwm_count_clock = 1'h1;
         cyc(3);
         pwm_count_clock = 1'h0;
      end
      cyc(6);
   endtask
   // ====
   // sequence
   initial begin
      cyc(20);
      reset_n = 1'h1;
      cyc(4);
      chk(oe_n, 1'h1, "pin idle");
      chk(pullup_en, 24'hFFFFFF, "pullups");
      channel_on = 24'hFFFFFF;
      cyc(30);
      chk({sink_drive, pullup_en}, {24'hFFFFFF, 24'h0}, "drive");
      for (int k = 0; k < 4; k++) begin
         cond = 4'h1 << k;
         cyc(10);
         chk(oe_n, 1'h0, "fault set");
         if (k == 3) chk(sink_drive, 24'h0, "shutdown");
         rdo;
         chk(rd[33:24], {cond, 6'h0}, "status");
         chk(oe_n, 1'h0, "clear while present");
         cond = 4'h0;
         cyc(10);
         chk(oe_n, 1'h0, "latched");
         host.frame(`LFD_CMD_CLEAR, 13'h0, 1'h1);
         chk(oe_n, 1'h1, "cleared");
      end
      chk(sink_drive, 24'hFFFFFF, "resume");
      // 10-bit depth first, then 8-bit for the rest of the run
      for (int m = 0; m < 2; m++) begin
         host.frame(`LFD_CMD_FC, m ? 13'h01E0 : 13'h01C0, 1'h1);
         chk(cur, 1'h1, "probe current");
         pcycle(24'h0, m ? 256 : 1024);
         chk(oe_n, 1'h1, "healthy");
         rdo;
         chk(rd[131:34], {48'h0, 24'h0, 24'hFFFFFF, 2'h0}, "samples");
      end
      host.frame(`LFD_CMD_NEG, 13'h0, 1'h1);
      pcycle(24'h0, 256);
      rdo;
      chk(rd[131:34], {48'hFFFFFFFFFFFF, 24'hFFFFFF, 24'h0, 2'h3}, "negated");
      pcycle(24'h000001, 256);
      chk(oe_n, 1'h0, "led open");
      pcycle(24'h0, 256);
      chk(oe_n, 1'h1, "led ok");
      for (int k = 0; k < 2; k++) begin
         adj_short_in = k ? 24'h800001 : 24'h0;
         host.frame(`LFD_CMD_ADJ, 13'h0, 1'h1);
         cyc(1100);
         chk(oe_n, k == 0, "adjacent pin");
         rdo;
         chk(rd[26:0], {k ? 3'h6 : 3'h3, adj_short_in}, "adjacent");
      end
      selftest_fail_in = 1'h1;
      host.frame(`LFD_CMD_SELF, 13'h0, 1'h1);
      rdo;
      chk(rd[29:27], 3'h6, "selftest");
      adj_short_in = 24'h0;
      selftest_fail_in = 1'h0;
      host.frame(`LFD_CMD_GRESET, 13'h0, 1'h1);
      chk({oe_n, cur}, 2'h2, "global reset");
      print_verdict;
   end
   initial begin
      cyc(90000);
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire
